// ---- inc/i2c_master_byte_engine_pkg.sv ----
// ============================================================
// register map and field layout
// ============================================================
package i2c_master_byte_engine_pkg;

  // byte addresses of the word registers
  localparam logic [3:0] ADDR_BUFFER = 4'h0; // transfer_buffer
  localparam logic [3:0] ADDR_CONTROL = 4'h4; // serial_control_two
  localparam logic [3:0] ADDR_STATUS = 4'h8; // serial_status_reg
  localparam logic [3:0] ADDR_BAUD = 4'hc; // baud_reload_value

  // serial_control_two bit positions
  localparam int CTL_START = 0; // start_request_bit
  localparam int CTL_RESTART = 1; // restart_request_bit
  localparam int CTL_STOP = 2; // stop_request_bit
  localparam int CTL_RECEIVE = 3; // receive_request_bit
  localparam int CTL_ACKSEQ = 4; // ack_sequence_request
  localparam int CTL_ACKVAL = 5; // ack_value_bit
  localparam int CTL_ACK_STATUS_BIT = 6; // ack_status_bit, read only

  // serial_status_reg bit positions
  localparam int STS_FULL = 0; // buffer_full_flag, read only
  localparam int STS_IRQ = 1; // serial_irq_flag, write one to clear
  localparam int STS_WRITE_COLLISION_FLAG = 2; // write_collision_flag, write one to clear
  localparam int STS_OVF = 3; // receive_overflow_flag, write one to clear
  localparam int STS_BUSY = 4; // engine not idle, read only

  // reset values
  localparam logic [7:0] BAUD_RESET = 8'h04; // baud_reload_value after reset
  localparam logic [7:0] BUFFER_RESET = 8'h00; // transfer_buffer after reset

  // engine sequences
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_RESTART = 3'b010,
    ST_STOP = 3'b011,
    ST_TX = 3'b100,
    ST_RX = 3'b101,
    ST_ACK = 3'b110
  } seq_t;

endpackage : i2c_master_byte_engine_pkg

// ---- core/i2c_master_byte_engine.sv ----
// How it works
// - idle buffer write sets full, starts shifting
// - bit changes in the same cycle as the fall; low, high one tick each
// - eighth fall clears full, releases data line
// - ninth clock ack level into ack status
// - after ninth: irq, counter stops, clock low
// - address byte sent msb first, eight bits
// - write during transmit dropped, collision flag set
// - start holds data low one tick before done
// - stop or restart finishes, then irq flag
// - receive request clocks in one byte
// - receive request ignored unless engine idle
// - receive: each rollover toggles clock, each fall shifts data
// - eighth receive fall: copy, full, irq, stop
// - receive mode buffer read clears full flag
// - byte arriving while full sets overflow flag
// - write during receive dropped, collision flag set
// - released clock holds counter at reload until seen high
// - ack sequence: value low tick, high tick, low
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module i2c_master_byte_engine (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe
);

  // ============================================================
  // state
  // ============================================================
  typedef struct packed {
    logic [1:0] scl_sync; // clock line synchroniser
    logic [1:0] sda_sync; // data line synchroniser
    i2c_master_byte_engine_pkg::seq_t st; // running sequence
    logic [1:0] ph; // phase within sequence or bit
    logic [3:0] bitn; // bit index 0..9
    logic [7:0] brg; // baud tick counter
    logic [7:0] buffer; // transfer_buffer
    logic [7:0] shifter; // shift_register
    logic [7:0] reload; // baud_reload_value
    logic start_req; // start_request_bit
    logic restart_req; // restart_request_bit
    logic stop_req; // stop_request_bit
    logic recv_req; // receive_request_bit
    logic ackseq_req; // ack_sequence_request
    logic ack_value; // ack_value_bit
    logic ack_status; // ack_status_bit
    logic full; // buffer_full_flag
    logic irq; // serial_irq_flag
    logic write_collision_flag; // write_collision_flag
    logic ovf; // receive_overflow_flag
    logic rx_mode; // buffer holds a received byte
    logic scl_oe; // pull clock line low
    logic sda_oe; // pull data line low
    logic ack; // bus answer
    logic [31:0] rdat; // bus read data
  } state_t;

  state_t q;
  state_t n;

  // pin drive for a running sequence: {scl released, sda released}
  function automatic logic [1:0] line_release(input i2c_master_byte_engine_pkg::seq_t st,
                                              input logic [1:0] ph,
                                              input logic [3:0] bitn,
                                              input logic tx_bit,
                                              input logic ackv);
    logic scl_rel;
    logic sda_rel;
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    unique case (st)
      i2c_master_byte_engine_pkg::ST_START: begin
        sda_rel = (ph == 2'd0);
      end
      i2c_master_byte_engine_pkg::ST_RESTART: begin
        scl_rel = (ph != 2'd0);
        sda_rel = (ph != 2'd2);
      end
      i2c_master_byte_engine_pkg::ST_STOP: begin
        scl_rel = (ph != 2'd0);
        sda_rel = (ph == 2'd2);
      end
      i2c_master_byte_engine_pkg::ST_TX: begin
        scl_rel = (ph == 2'd1);
        sda_rel = (bitn == 4'd8) ? 1'b1 : tx_bit;
      end
      i2c_master_byte_engine_pkg::ST_RX: begin
        scl_rel = (ph == 2'd1);
      end
      i2c_master_byte_engine_pkg::ST_ACK: begin
        scl_rel = (ph == 2'd1);
        sda_rel = ackv;
      end
      i2c_master_byte_engine_pkg::ST_IDLE: begin
        scl_rel = 1'b1;
      end
    endcase
    return {scl_rel, sda_rel};
  endfunction : line_release

  // ============================================================
  // next state
  // ============================================================
  logic req;
  logic wr;
  logic rd;
  logic waiting;
  logic scl_hi;
  logic sda_in;
  logic pending;
  logic [1:0] rel;
  logic [7:0] wbyte;

  // one combinational pass over bus, engine and pins
  always_comb begin
    n = q;
    scl_hi = q.scl_sync[1];
    sda_in = q.sda_sync[1];
    n.scl_sync = {q.scl_sync[0], i_scl};
    n.sda_sync = {q.sda_sync[0], i_sda};
    req = i_wb_cyc & i_wb_stb & ~q.ack;
    wr = req & i_wb_we & i_wb_sel[0];
    rd = req & ~i_wb_we;
    wbyte = i_wb_dat[7:0];
    pending = q.start_req | q.restart_req | q.stop_req | q.recv_req | q.ackseq_req;
    // released clock still held low by a slave keeps the counter at its reload value
    waiting = ~q.scl_oe & ~scl_hi;
    n.ack = req;
    n.rdat = 32'h0000_0000;

    // software side: flag clears first, so hardware sets below win
    if (wr && i_wb_adr == i2c_master_byte_engine_pkg::ADDR_STATUS) begin
      if (wbyte[i2c_master_byte_engine_pkg::STS_IRQ]) begin
        n.irq = 1'b0;
      end
      if (wbyte[i2c_master_byte_engine_pkg::STS_WRITE_COLLISION_FLAG]) begin
        n.write_collision_flag = 1'b0;
      end
      if (wbyte[i2c_master_byte_engine_pkg::STS_OVF]) begin
        n.ovf = 1'b0;
      end
    end
    if (wr && i_wb_adr == i2c_master_byte_engine_pkg::ADDR_BAUD) begin
      n.reload = wbyte;
    end
    if (wr && i_wb_adr == i2c_master_byte_engine_pkg::ADDR_CONTROL) begin
      n.ack_value = wbyte[i2c_master_byte_engine_pkg::CTL_ACKVAL];
      // requests only taken by an idle engine, one at a time
      if (q.st == i2c_master_byte_engine_pkg::ST_IDLE && !pending) begin
        n.start_req = wbyte[i2c_master_byte_engine_pkg::CTL_START];
        n.restart_req = wbyte[i2c_master_byte_engine_pkg::CTL_RESTART];
        n.stop_req = wbyte[i2c_master_byte_engine_pkg::CTL_STOP];
        n.recv_req = wbyte[i2c_master_byte_engine_pkg::CTL_RECEIVE];
        n.ackseq_req = wbyte[i2c_master_byte_engine_pkg::CTL_ACKSEQ];
      end
    end
    if (wr && i_wb_adr == i2c_master_byte_engine_pkg::ADDR_BUFFER) begin
      if (q.st != i2c_master_byte_engine_pkg::ST_IDLE || pending) begin
        n.write_collision_flag = 1'b1;
      end else begin
        n.buffer = wbyte;
        n.shifter = wbyte;
        n.full = 1'b1;
        n.rx_mode = 1'b0;
        n.st = i2c_master_byte_engine_pkg::ST_TX;
        n.ph = 2'd0;
        n.bitn = 4'd0;
        n.brg = q.reload;
      end
    end

    // read data and read side effects
    if (rd) begin
      unique case (i_wb_adr)
        i2c_master_byte_engine_pkg::ADDR_BUFFER: begin
          n.rdat = {24'h00_0000, q.buffer};
          if (q.rx_mode) begin
            n.full = 1'b0;
          end
        end
        i2c_master_byte_engine_pkg::ADDR_CONTROL: begin
          n.rdat = {25'h000_0000, q.ack_status, q.ack_value, q.ackseq_req,
                    q.recv_req, q.stop_req, q.restart_req, q.start_req};
        end
        i2c_master_byte_engine_pkg::ADDR_STATUS: begin
          n.rdat = {27'h000_0000, (q.st != i2c_master_byte_engine_pkg::ST_IDLE),
                    q.ovf, q.write_collision_flag, q.irq, q.full};
        end
        i2c_master_byte_engine_pkg::ADDR_BAUD: begin
          n.rdat = {24'h00_0000, q.reload};
        end
        default: begin
          n.rdat = 32'h0000_0000; // unmapped reads zero
        end
      endcase
    end

    // idle engine picks up a pending request
    if (q.st == i2c_master_byte_engine_pkg::ST_IDLE) begin
      n.ph = (n.st == i2c_master_byte_engine_pkg::ST_TX) ? 2'd0 : q.ph;
      if (q.start_req) begin
        n.st = i2c_master_byte_engine_pkg::ST_START;
      end else if (q.restart_req) begin
        n.st = i2c_master_byte_engine_pkg::ST_RESTART;
      end else if (q.stop_req) begin
        n.st = i2c_master_byte_engine_pkg::ST_STOP;
      end else if (q.recv_req) begin
        n.st = i2c_master_byte_engine_pkg::ST_RX;
      end else if (q.ackseq_req) begin
        n.st = i2c_master_byte_engine_pkg::ST_ACK;
      end
      if (pending) begin
        n.ph = 2'd0;
        n.bitn = 4'd0;
        n.brg = q.reload;
      end
    end else if (waiting) begin
      n.brg = q.reload;
    end else if (q.brg != 8'h00) begin
      n.brg = q.brg - 8'h01;
      // ack level followed while the ninth clock is high
      if (q.st == i2c_master_byte_engine_pkg::ST_TX && q.ph == 2'd1 && q.bitn == 4'd8) begin
        n.ack_status = sda_in;
      end
    end else begin
      // rollover: end of a phase
      n.brg = q.reload;
      n.ph = q.ph + 2'd1;
      unique case (q.st)
        i2c_master_byte_engine_pkg::ST_START: begin
          if (q.ph == 2'd1) begin
            n.start_req = 1'b0;
            n.irq = 1'b1;
            n.st = i2c_master_byte_engine_pkg::ST_IDLE;
          end
        end
        i2c_master_byte_engine_pkg::ST_RESTART: begin
          if (q.ph == 2'd2) begin
            n.restart_req = 1'b0;
            n.irq = 1'b1;
            n.st = i2c_master_byte_engine_pkg::ST_IDLE;
          end
        end
        i2c_master_byte_engine_pkg::ST_STOP: begin
          if (q.ph == 2'd2) begin
            n.stop_req = 1'b0;
            n.irq = 1'b1;
            n.st = i2c_master_byte_engine_pkg::ST_IDLE;
          end
        end
        i2c_master_byte_engine_pkg::ST_TX: begin
          if (q.ph == 2'd1) begin
            // falling edge ends the bit
            n.ph = 2'd0;
            n.bitn = q.bitn + 4'd1;
            n.shifter = {q.shifter[6:0], 1'b0};
            if (q.bitn == 4'd7) begin
              n.full = 1'b0;
            end
            if (q.bitn == 4'd8) begin
              n.ack_status = sda_in;
              n.irq = 1'b1;
              n.st = i2c_master_byte_engine_pkg::ST_IDLE;
            end
          end
        end
        i2c_master_byte_engine_pkg::ST_RX: begin
          if (q.ph == 2'd1) begin
            n.ph = 2'd0;
            n.bitn = q.bitn + 4'd1;
            n.shifter = {q.shifter[6:0], sda_in};
            if (q.bitn == 4'd7) begin
              n.recv_req = 1'b0;
              n.buffer = {q.shifter[6:0], sda_in};
              n.full = 1'b1;
              n.ovf = q.ovf | q.full;
              n.irq = 1'b1;
              n.rx_mode = 1'b1;
              n.st = i2c_master_byte_engine_pkg::ST_IDLE;
            end
          end
        end
        i2c_master_byte_engine_pkg::ST_ACK: begin
          if (q.ph == 2'd1) begin
            n.ackseq_req = 1'b0;
            n.irq = 1'b1;
            n.st = i2c_master_byte_engine_pkg::ST_IDLE;
          end
        end
        i2c_master_byte_engine_pkg::ST_IDLE: begin
          n.ph = q.ph;
        end
      endcase
    end

    // pin drive follows the sequence that will run next cycle
    rel = line_release(n.st, n.ph, n.bitn, n.shifter[7], q.ack_value);
    if (n.st != i2c_master_byte_engine_pkg::ST_IDLE) begin
      n.scl_oe = ~rel[1];
      n.sda_oe = ~rel[0];
    end else if (q.st != i2c_master_byte_engine_pkg::ST_IDLE) begin
      // line levels left behind when a sequence finishes
      unique case (q.st)
        i2c_master_byte_engine_pkg::ST_START: begin
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b1;
        end
        i2c_master_byte_engine_pkg::ST_RESTART: begin
          n.scl_oe = 1'b1;
          n.sda_oe = 1'b1;
        end
        i2c_master_byte_engine_pkg::ST_STOP: begin
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b0;
        end
        default: begin
          n.scl_oe = 1'b1;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // registers
  // ============================================================
  // single clocked process, synchronous reset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      q <= '0;
      q.scl_sync <= 2'b11;
      q.sda_sync <= 2'b11;
      q.st <= i2c_master_byte_engine_pkg::ST_IDLE;
      q.buffer <= i2c_master_byte_engine_pkg::BUFFER_RESET;
      q.reload <= i2c_master_byte_engine_pkg::BAUD_RESET;
    end else begin
      q <= n;
    end
  end

  // ============================================================
  // outputs
  // ============================================================
  assign o_wb_ack = q.ack;
  assign o_wb_dat = q.rdat;
  assign o_scl = q.rdat[31] & 1'b0;
  assign o_scl_oe = q.scl_oe;
  assign o_sda = q.rdat[31] & 1'b0;
  assign o_sda_oe = q.sda_oe;

endmodule : i2c_master_byte_engine

// ---- verif/i2c_slave_model.sv ----
`timescale 1ns/1ps
// ============================================================
// behavioural slave: acks writes, serves read bytes msb first
// ============================================================
module i2c_slave_model (
  input wire logic i_ref_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_nack,
  input wire logic [7:0] i_rd_byte,
  output logic o_sda_oe
);
  logic scl_q = 1'b1, sda_q = 1'b1, first = 1'b1, rd = 1'b0; // line history and mode
  logic drv_ack = 1'b0, drv_rd = 1'b0, last = 1'b1; // drive enables, last sampled bit
  logic [3:0] cnt = 4'h0; // falling edges in this byte
  logic [2:0] idx = 3'h7; // read bit being served
  // byte changes while clock is low reach the line at once
  assign o_sda_oe = drv_ack | (drv_rd & ~i_rd_byte[idx]);
  // framing follows clock edges seen on the wired lines
  always @(posedge i_ref_clk) begin
    scl_q <= i_scl;
    sda_q <= i_sda;
    if (scl_q && i_scl && sda_q != i_sda) begin
      // start or stop: new frame, let go of data; the fall that ends
      // a start belongs to no bit, so it is marked to be skipped
      cnt <= 4'hf;
      first <= 1'b1;
      drv_ack <= 1'b0;
      drv_rd <= 1'b0;
    end else if (!scl_q && i_scl) begin
      last <= i_sda;
    end else if (scl_q && !i_scl) begin
      if (cnt == 4'hf) begin
        // first fall after a start opens the byte
        cnt <= 4'h0;
      end else if (cnt == 4'h8) begin
        // ninth fall: serve next read byte only after an ack
        cnt <= 4'h0;
        first <= 1'b0;
        drv_ack <= 1'b0;
        drv_rd <= rd && !last;
        idx <= 3'h7;
      end else begin
        cnt <= cnt + 4'h1;
        idx <= 3'h6 - cnt[2:0];
        if (cnt == 4'h7) begin
          drv_rd <= 1'b0;
          drv_ack <= ~i_nack & (first | ~rd);
        end
        if (cnt == 4'h7 && first) begin
          rd <= last;
        end
      end
    end
  end
endmodule : i2c_slave_model

// ---- verif/i2c_master_byte_engine_asserts.sv ----
`timescale 1ns/1ps
// ============================================================
// port checker
// ============================================================
module i2c_master_byte_engine_asserts (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic i_scl,
  input wire logic o_scl,
  input wire logic o_scl_oe,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // a request not yet answered
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  // one-cycle answer
  sequence s_answer;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  sequence s_unmapped_rd;
    s_req ##0 (!i_wb_we && i_wb_adr[1:0] != 2'b00);
  endsequence
  chk_bus_answer: assert property (s_req |=> s_answer)
    else $error("bus answer not one cycle after request");
  chk_no_stray_ack: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  chk_idle_dat: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("read data outside ack");
  chk_upper_dat: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  chk_unmapped_zero: assert property (s_unmapped_rd |=> o_wb_dat == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_write_dat: assert property ((s_req ##0 i_wb_we) |=> o_wb_dat == 32'h0000_0000)
    else $error("write answer carries data");
  chk_open_drain: assert property (o_scl == 1'b0 && o_sda == 1'b0)
    else $error("line output level not low");
  chk_clock_low_phase: assert property ($fell(o_scl_oe) |-> $past(o_scl_oe, 4))
    else $error("clock low phase too short");
  chk_clock_high_phase: assert property (
    $rose(o_scl_oe) && $past(i_scl) |-> $past(i_scl, 5))
    else $error("clock high phase too short");
endmodule : i2c_master_byte_engine_asserts
bind i2c_master_byte_engine i2c_master_byte_engine_asserts u_asserts (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_scl(i_scl), .o_scl(o_scl),
  .o_scl_oe(o_scl_oe), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe));

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`define PK(n) i2c_master_byte_engine_pkg::n
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
// ============================================================
// bench top
// ============================================================
module testbench;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, wb_req = 1'b0, wb_we = 1'b0; // clock, reset, bus
  logic [3:0] wb_adr = 4'h0; // bus address
  logic [31:0] wb_wdat = 32'h0000_0000, wb_rdat; // bus data
  logic wb_ack, scl_o, sda_o, scl_oe, sda_oe, slave_oe; // design and slave drives
  logic slave_nack = 1'b0, scl_d = 1'b1; // slave refuses ack; clock history
  logic [7:0] slave_byte = 8'h00, q; // byte served by slave
  logic [8:0] wire_bits = 9'h000; // last nine bits seen on the wire
  int miscompares = 0, n_compared = 0;
  wire logic scl_line = ~scl_oe; // pull-up; slave never stretches
  wire logic sda_line = ~(sda_oe | slave_oe);
  always #10 i_ref_clk = ~i_ref_clk;
  i2c_master_byte_engine u_i2c_master_byte_engine (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_wb_cyc(wb_req), .i_wb_stb(wb_req), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
    .i_wb_sel(4'h1), .i_wb_dat(wb_wdat), .o_wb_ack(wb_ack), .o_wb_dat(wb_rdat),
    .i_scl(scl_line), .o_scl(scl_o), .o_scl_oe(scl_oe), .i_sda(sda_line), .o_sda(sda_o),
    .o_sda_oe(sda_oe));
  i2c_slave_model u_i2c_slave_model (.i_ref_clk(i_ref_clk), .i_scl(scl_line),
    .i_sda(sda_line), .i_nack(slave_nack), .i_rd_byte(slave_byte), .o_sda_oe(slave_oe));
  // wire monitor: data sampled at each clock rise
  always @(posedge i_ref_clk) begin
    scl_d <= scl_line;
    if (scl_line && !scl_d) begin
      wire_bits <= {wire_bits[7:0], sda_line};
    end
  end
  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    int n;
    begin
      n = 0;
      @(posedge i_ref_clk);
      wb_req <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= {24'h00_0000, d};
      do begin
        @(posedge i_ref_clk);
        n++;
      end while (wb_ack !== 1'b1 && n < 20);
      r = wb_rdat[7:0];
      wb_req <= 1'b0;
      if (wb_ack !== 1'b1) begin
        miscompares++;
        tally_and_finish();
      end
    end
  endtask : wb
  // poll for the irq flag, see it persist, then clear it
  task automatic wait_irq();
    int n;
    logic [7:0] r;
    begin
      n = 0;
      r = 8'h00;
      while (r[`PK(STS_IRQ)] !== 1'b1 && n < 500) begin
        wb(1'b0, `PK(ADDR_STATUS), 8'h00, r);
        n++;
      end
      if (r[`PK(STS_IRQ)] !== 1'b1) begin
        miscompares++;
        tally_and_finish();
      end
      wb(1'b0, `PK(ADDR_STATUS), 8'h00, r);
      `CHECK(r[`PK(STS_IRQ)], 1'b1)
      wb(1'b1, `PK(ADDR_STATUS), 8'h02, r);
    end
  endtask : wait_irq
  // send one byte, with a colliding write in mid-byte
  task automatic do_tx(input logic [7:0] b, input logic nk);
    logic [7:0] r;
    begin
      slave_nack <= nk;
      wb(1'b1, `PK(ADDR_BUFFER), b, r);
      wb(1'b0, `PK(ADDR_STATUS), 8'h00, r);
      `CHECK(r[`PK(STS_FULL)], 1'b1)
      wb(1'b1, `PK(ADDR_BUFFER), ~b, r);
      wb(1'b0, `PK(ADDR_STATUS), 8'h00, r);
      `CHECK(r[`PK(STS_WRITE_COLLISION_FLAG)], 1'b1)
      wb(1'b1, `PK(ADDR_STATUS), 8'h04, r);
      wb(1'b1, `PK(ADDR_CONTROL), 8'h08, r);
      wait_irq();
      wb(1'b0, `PK(ADDR_STATUS), 8'h00, r);
      `CHECK(r[4:0], 5'h00)
      wb(1'b0, `PK(ADDR_CONTROL), 8'h00, r);
      `CHECK(r[`PK(CTL_ACK_STATUS_BIT)], nk)
      `CHECK(r[`PK(CTL_RECEIVE)], 1'b0)
      wb(1'b0, `PK(ADDR_BUFFER), 8'h00, r);
      `CHECK(r, b)
      `CHECK(wire_bits, {b, nk})
    end
  endtask : do_tx
  // receive one byte; a write and a second request land mid-byte
  task automatic do_rx(input logic [7:0] b, input logic rd_it, input logic ov);
    logic [7:0] r;
    begin
      slave_byte <= b;
      wb(1'b1, `PK(ADDR_CONTROL), 8'h08, r);
      wb(1'b1, `PK(ADDR_BUFFER), 8'h11, r);
      wb(1'b1, `PK(ADDR_CONTROL), 8'h08, r);
      wb(1'b0, `PK(ADDR_STATUS), 8'h00, r);
      `CHECK(r[`PK(STS_WRITE_COLLISION_FLAG)], 1'b1)
      wb(1'b1, `PK(ADDR_STATUS), 8'h04, r);
      wait_irq();
      wb(1'b0, `PK(ADDR_CONTROL), 8'h00, r);
      `CHECK(r[`PK(CTL_RECEIVE)], 1'b0)
      wb(1'b0, `PK(ADDR_STATUS), 8'h00, r);
      `CHECK(r[4:0], {1'b0, ov, 3'b001})
      if (rd_it) begin
        wb(1'b0, `PK(ADDR_BUFFER), 8'h00, r);
        `CHECK(r, b)
        wb(1'b0, `PK(ADDR_STATUS), 8'h00, r);
        `CHECK(r[`PK(STS_FULL)], 1'b0)
      end
    end
  endtask : do_rx
  // value first, then the sequence request
  task automatic do_ack(input logic v);
    logic [7:0] r;
    begin
      wb(1'b1, `PK(ADDR_CONTROL), {2'b00, v, 5'h00}, r);
      wb(1'b1, `PK(ADDR_CONTROL), {2'b00, v, 5'h10}, r);
      wait_irq();
      wb(1'b0, `PK(ADDR_CONTROL), 8'h00, r);
      `CHECK(r[`PK(CTL_ACKSEQ)], 1'b0)
      `CHECK(wire_bits[0], v)
    end
  endtask : do_ack
  task automatic tally_and_finish();
    begin
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask : tally_and_finish
  // main sequence: reset values, write then read transfer, stop
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    wb(1'b0, `PK(ADDR_BAUD), 8'h00, q);
    `CHECK(q, `PK(BAUD_RESET))
    wb(1'b0, 4'h2, 8'h00, q);
    `CHECK(q, 8'h00)
    wb(1'b1, `PK(ADDR_BAUD), 8'h07, q);
    wb(1'b0, `PK(ADDR_BAUD), 8'h00, q);
    `CHECK(q, 8'h07)
    wb(1'b1, `PK(ADDR_BAUD), `PK(BAUD_RESET), q);
    wb(1'b1, `PK(ADDR_CONTROL), 8'h01, q);
    wb(1'b1, `PK(ADDR_BUFFER), 8'h5a, q);
    wb(1'b0, `PK(ADDR_STATUS), 8'h00, q);
    `CHECK(q[`PK(STS_WRITE_COLLISION_FLAG)], 1'b1)
    wb(1'b1, `PK(ADDR_STATUS), 8'h04, q);
    wait_irq();
    wb(1'b0, `PK(ADDR_BUFFER), 8'h00, q);
    `CHECK(q, `PK(BUFFER_RESET))
    do_tx(8'ha4, 1'b0);
    do_tx(8'h3c, 1'b1);
    wb(1'b1, `PK(ADDR_CONTROL), 8'h02, q);
    wait_irq();
    do_tx(8'ha5, 1'b0);
    do_rx(8'h96, 1'b1, 1'b0);
    do_ack(1'b0);
    do_rx(8'h5a, 1'b0, 1'b0);
    do_ack(1'b0);
    do_rx(8'hc3, 1'b0, 1'b1);
    wb(1'b0, `PK(ADDR_BUFFER), 8'h00, q);
    wb(1'b0, `PK(ADDR_STATUS), 8'h00, q);
    `CHECK(q[`PK(STS_OVF)], 1'b1)
    wb(1'b1, `PK(ADDR_STATUS), 8'h08, q);
    do_ack(1'b1);
    wb(1'b1, `PK(ADDR_CONTROL), 8'h04, q);
    wait_irq();
    wb(1'b0, `PK(ADDR_STATUS), 8'h00, q);
    `CHECK(q[4:0], 5'h00)
    `CHECK({scl_line, sda_line}, 2'b11)
    tally_and_finish();
  end
endmodule : testbench
